// ### common/tmrwm_pkg.sv
package tmrwm_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL_A    = 4'h0;
  localparam logic [3:0] OFS_CTRL_B    = 4'h1;
  localparam logic [3:0] OFS_COUNT     = 4'h2;
  localparam logic [3:0] OFS_CMP_A     = 4'h3;
  localparam logic [3:0] OFS_CMP_B     = 4'h4;
  localparam logic [3:0] OFS_FLAGS     = 4'h5;
  localparam logic [3:0] OFS_PORT_DIR  = 4'h6;
  localparam logic [3:0] OFS_PORT_DATA = 4'h7;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int POS_ACT_A    = 6;
  localparam int POS_ACT_B    = 4;
  localparam int POS_MODE_LO  = 0;
  localparam int POS_MODE_HI  = 3;
  localparam int POS_CLK_SEL  = 0;
  localparam int POS_FLG_OVF  = 0;
  localparam int POS_FLG_CMPA = 1;
  localparam int POS_FLG_CMPB = 2;

  // ---------------------------------------------------------------
  // Reset values and count limits
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [7:0] CNT_MAX   = 8'hFF;
  localparam logic [7:0] CNT_BOT   = 8'h00;
  localparam logic [7:0] CNT_STEP  = 8'h01;

  // ---------------------------------------------------------------
  // Waveform modes and output actions
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_NORMAL    = 3'h0;
  localparam logic [2:0] MODE_CLR_MATCH = 3'h2;
  localparam logic [2:0] MODE_FPWM_MAX  = 3'h3;
  localparam logic [2:0] MODE_FPWM_CMP  = 3'h7;
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  // ---------------------------------------------------------------
  // Prescaler selections and divide masks
  // ---------------------------------------------------------------
  localparam int         PRESC_W   = 10;
  localparam logic [2:0] SEL_STOP  = 3'h0;
  localparam logic [2:0] SEL_DIV1  = 3'h1;
  localparam logic [2:0] SEL_DIV8  = 3'h2;
  localparam logic [2:0] SEL_DIV64 = 3'h3;
  localparam logic [2:0] SEL_D256  = 3'h4;
  localparam logic [2:0] SEL_D1024 = 3'h5;
  localparam logic [9:0] MSK_DIV8  = 10'h007;
  localparam logic [9:0] MSK_DIV64 = 10'h03F;
  localparam logic [9:0] MSK_D256  = 10'h0FF;
  localparam logic [9:0] MSK_D1024 = 10'h3FF;

endpackage

// ### common/tmrwm_tick_if.sv
`timescale 1ns/1ps
// Carries the prescale selection out and the timer clock enable back.
interface tmrwm_tick_if;
  logic [2:0] sel;
  logic       tick;
  modport ctl (output sel, input tick);
  modport gen (input sel, output tick);
endinterface

// ### rtl/tmrwm_prescaler.sv
`timescale 1ns/1ps
module tmrwm_prescaler
  import tmrwm_pkg::*;
#(
  parameter int W = PRESC_W
)(
  input  wire logic   clk,
  input  wire logic   nrst,
  tmrwm_tick_if.gen   tif
);

  // Refuses a divider too narrow for the largest prescale factor.
  if (W < PRESC_W) begin : g_bad_width
    $error("Prescaler too narrow for the largest divide.");
  end

  logic [W-1:0] div_cnt;

  // Returns the low-bit mask whose all-ones state marks a tick.
  function automatic logic [9:0] div_mask(input logic [2:0] s);
    case (s)
      SEL_DIV8:  div_mask = MSK_DIV8;
      SEL_DIV64: div_mask = MSK_DIV64;
      SEL_D256:  div_mask = MSK_D256;
      default:   div_mask = MSK_D1024;
    endcase
  endfunction

  // Free-running divider shared by the divide-by-8 to 1024 factors; divide by 1 does not use it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // One-cycle timer clock enable at the selected divide.
  always_comb begin
    if (tif.sel == SEL_STOP || tif.sel > SEL_D1024) begin
      tif.tick = 1'b0;
    end else if (tif.sel == SEL_DIV1) begin
      tif.tick = 1'b1;
    end else begin
      tif.tick = &(div_cnt[9:0] | ~div_mask(tif.sel));
    end
  end

  chk_div8_spacing: assert property (@(posedge clk) disable iff (!nrst)
    (tif.tick && tif.sel == SEL_DIV8) |=> (!tif.tick || tif.sel != SEL_DIV8)[*7])
    else $error("Divide by 8 tick came early.");

endmodule

// ### rtl/tmrwm_top.sv
`timescale 1ns/1ps
module tmrwm_top
  import tmrwm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  input  wire logic       ovf_ack,
  input  wire logic       cmp_a_ack,
  input  wire logic       cmp_b_ack,
  output logic            overflow_flag,
  output logic            compare_a_flag,
  output logic            compare_b_flag,
  output logic            wave_out_a,
  output logic            wave_out_a_oe_n,
  output logic            wave_out_b,
  output logic            wave_out_b_oe_n
);

  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  logic [1:0] output_action_a;
  logic [1:0] output_action_b;
  logic [1:0] mode_lo;
  logic       mode_sel_high_bit;
  logic [2:0] clk_sel;
  logic [7:0] count_value;
  logic [7:0] compare_value_a;
  logic [7:0] compare_value_b;
  logic [7:0] cmp_a_buf;
  logic [7:0] cmp_b_buf;
  logic [1:0] port_dir;
  logic [1:0] port_data;
  logic       wave_a;
  logic       wave_b;
  logic       match_block;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic [2:0] waveform_mode_sel;
  logic       clear_on_match_mode;
  logic       fast_pwm;
  logic [7:0] top_value;
  logic       tick;
  logic       at_top;
  logic       wr_count;
  logic       match_en;
  logic       match_a;
  logic       match_b;
  logic       top_clear;
  logic       wrap_ovf;
  logic       flag_wr;

  tmrwm_tick_if tick_bus ();

  tmrwm_prescaler #(.W(PRESC_W)) u_presc (
    .clk  (clk),
    .nrst (nrst),
    .tif  (tick_bus.gen)
  );

  assign tick_bus.sel = clk_sel;
  assign tick         = tick_bus.tick;

  // Counting depends on the mode selector alone, never on actions.
  assign waveform_mode_sel   = {mode_sel_high_bit, mode_lo};
  assign clear_on_match_mode = (waveform_mode_sel == MODE_CLR_MATCH);
  assign fast_pwm            = (waveform_mode_sel == MODE_FPWM_MAX)
                             || (waveform_mode_sel == MODE_FPWM_CMP);
  assign top_value = (waveform_mode_sel == MODE_FPWM_MAX) ? CNT_MAX
                   : compare_value_a;
  assign at_top    = (count_value == top_value);
  assign wr_count  = wr_en && (addr == OFS_COUNT);
  assign flag_wr   = wr_en && (addr == OFS_FLAGS);

  // Matches are taken on a timer tick unless a count write blocks them.
  assign match_en  = tick && !match_block && !wr_count;
  assign match_a   = match_en && (count_value == compare_value_a);
  assign match_b   = match_en && (count_value == compare_value_b);

  // Top clearing: PWM always wraps at top, clear-on-match needs a match.
  assign top_clear = tick && !wr_count && at_top
                   && (fast_pwm || (clear_on_match_mode && !match_block));

  // Overflow event per mode: at top in PWM, at the max wrap otherwise.
  assign wrap_ovf  = tick && !wr_count
                   && (fast_pwm ? at_top : (count_value == CNT_MAX));

  // Next internal waveform level for one channel on a tick.
  function automatic logic next_wave(
    input logic       cur,
    input logic [1:0] act,
    input logic       pwm,
    input logic       tog_ok,
    input logic       wrap,
    input logic       match
  );
    next_wave = cur;
    if (pwm && wrap && act[1]) begin
      next_wave = (act == ACT_CLEAR);
    end else if (match) begin
      case (act)
        ACT_TOGGLE: next_wave = (!pwm || tog_ok) ? !cur : cur;
        ACT_CLEAR:  next_wave = 1'b0;
        ACT_SET:    next_wave = 1'b1;
        default:    next_wave = cur;
      endcase
    end
  endfunction

  // Hands the pin back to port data at action zero or at a refused PWM toggle.
  function automatic logic on_port(input logic [1:0] act, input logic pwm, input logic tog_ok);
    on_port = (act == ACT_NONE) || (pwm && act == ACT_TOGGLE && !tog_ok);
  endfunction

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Software writes to mode, action, clock, direction and port data.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      output_action_a   <= ACT_NONE;
      output_action_b   <= ACT_NONE;
      mode_lo           <= MODE_NORMAL[1:0];
      mode_sel_high_bit <= 1'b0;
      clk_sel           <= SEL_STOP;
      port_dir          <= 2'h0;
      port_data         <= 2'h0;
    end else if (wr_en) begin
      case (addr)
        OFS_CTRL_A: begin
          output_action_a <= wdata[POS_ACT_A +: 2];
          output_action_b <= wdata[POS_ACT_B +: 2];
          mode_lo         <= wdata[POS_MODE_LO +: 2];
        end
        OFS_CTRL_B: begin
          mode_sel_high_bit <= wdata[POS_MODE_HI];
          clk_sel           <= wdata[POS_CLK_SEL +: 3];
        end
        OFS_PORT_DIR:  port_dir  <= wdata[1:0];
        OFS_PORT_DATA: port_data <= wdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  // A write loads the count directly in every mode, beating the tick.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_value <= RST_BYTE;
    end else if (wr_count) begin
      count_value <= wdata;
    end else if (top_clear) begin
      count_value <= CNT_BOT;
    end else if (tick) begin
      count_value <= count_value + CNT_STEP;
    end
  end

  // Blocks the matches of the next timer tick after a count write.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      match_block <= 1'b0;
    end else if (wr_count) begin
      match_block <= 1'b1;
    end else if (tick) begin
      match_block <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Compare registers
  // ---------------------------------------------------------------
  // Buffers always take software writes; active values follow them
  // at once outside PWM and only at the top wrap in PWM.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmp_a_buf       <= RST_BYTE;
      cmp_b_buf       <= RST_BYTE;
      compare_value_a <= RST_BYTE;
      compare_value_b <= RST_BYTE;
    end else begin
      if (wr_en && addr == OFS_CMP_A) begin
        cmp_a_buf <= wdata;
      end
      if (wr_en && addr == OFS_CMP_B) begin
        cmp_b_buf <= wdata;
      end
      if (!fast_pwm && wr_en && addr == OFS_CMP_A) begin
        compare_value_a <= wdata;
      end else if (fast_pwm && top_clear) begin
        compare_value_a <= cmp_a_buf;
      end
      if (!fast_pwm && wr_en && addr == OFS_CMP_B) begin
        compare_value_b <= wdata;
      end else if (fast_pwm && top_clear) begin
        compare_value_b <= cmp_b_buf;
      end
    end
  end

  // ---------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------
  // Hardware sets win over a clear by write-one or by service.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      overflow_flag <= 1'b0;
    end else if (wrap_ovf) begin
      overflow_flag <= 1'b1;
    end else if (ovf_ack || (flag_wr && wdata[POS_FLG_OVF])) begin
      overflow_flag <= 1'b0;
    end
  end

  // Compare A flag, raised at top in clear-on-match as on any match.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      compare_a_flag <= 1'b0;
    end else if (match_a) begin
      compare_a_flag <= 1'b1;
    end else if (cmp_a_ack || (flag_wr && wdata[POS_FLG_CMPA])) begin
      compare_a_flag <= 1'b0;
    end
  end

  // Compare B flag.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      compare_b_flag <= 1'b0;
    end else if (match_b) begin
      compare_b_flag <= 1'b1;
    end else if (cmp_b_ack || (flag_wr && wdata[POS_FLG_CMPB])) begin
      compare_b_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Waveform generator and pins
  // ---------------------------------------------------------------
  // Internal waveform registers; the toggle in PWM is for A only.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wave_a <= 1'b0;
      wave_b <= 1'b0;
    end else if (tick) begin
      wave_a <= next_wave(wave_a, output_action_a, fast_pwm,
                          mode_sel_high_bit, top_clear, match_a);
      wave_b <= next_wave(wave_b, output_action_b, fast_pwm,
                          1'b0, top_clear, match_b);
    end
  end

  // Pin drivers: waveform overrides port data unless action is zero or a refused toggle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wave_out_a      <= 1'b0;
      wave_out_b      <= 1'b0;
      wave_out_a_oe_n <= 1'b1;
      wave_out_b_oe_n <= 1'b1;
    end else begin
      wave_out_a <= on_port(output_action_a, fast_pwm, mode_sel_high_bit)
                    ? port_data[0] : wave_a;
      wave_out_b <= on_port(output_action_b, fast_pwm, 1'b0)
                    ? port_data[1] : wave_b;
      wave_out_a_oe_n <= !port_dir[0];
      wave_out_b_oe_n <= !port_dir[1];
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= RST_BYTE;
    end else if (rd_en) begin
      case (addr)
        OFS_CTRL_A:    rdata <= {output_action_a, output_action_b, 2'h0, mode_lo};
        OFS_CTRL_B:    rdata <= {4'h0, mode_sel_high_bit, clk_sel};
        OFS_COUNT:     rdata <= count_value;
        OFS_CMP_A:     rdata <= cmp_a_buf;
        OFS_CMP_B:     rdata <= cmp_b_buf;
        OFS_FLAGS:     rdata <= {5'h00, compare_b_flag, compare_a_flag, overflow_flag};
        OFS_PORT_DIR:  rdata <= {6'h00, port_dir};
        OFS_PORT_DATA: rdata <= {6'h00, port_data};
        default:       rdata <= RST_BYTE;
      endcase
    end else begin
      rdata <= RST_BYTE;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_normal_wrap: assert property (
    (tick && !wr_count && waveform_mode_sel == MODE_NORMAL && count_value == CNT_MAX)
    |=> (count_value == CNT_BOT) && overflow_flag)
    else $error("Normal mode did not wrap to zero with overflow.");

  chk_ctc_clear: assert property (
    (tick && !wr_count && !match_block && clear_on_match_mode
     && count_value == compare_value_a)
    |=> (count_value == CNT_BOT) && compare_a_flag)
    else $error("Clear-on-match did not clear at compare A.");

  chk_write_block: assert property (
    (tick && match_block && !wr_count && !compare_a_flag) |=> !compare_a_flag)
    else $error("Compare A flag set in a blocked tick.");

  chk_pwm_bottom: assert property (
    (fast_pwm && top_clear && output_action_a == ACT_CLEAR)
    |=> wave_a ##1 (wave_out_a || output_action_a != ACT_CLEAR))
    else $error("Non-inverted PWM not set at bottom.");

  chk_pwm_inv_top: assert property (
    (fast_pwm && top_clear && output_action_a == ACT_SET)
    |=> !wave_a && count_value == CNT_BOT)
    else $error("Inverted PWM not cleared at bottom.");

  chk_buf_load: assert property (
    (fast_pwm && top_clear && !(wr_en && addr == OFS_CMP_A))
    |=> compare_value_a == $past(cmp_a_buf))
    else $error("Buffered compare A not loaded at wrap.");

  chk_pwm_hold: assert property (
    (fast_pwm && !top_clear) |=> $stable(compare_value_a))
    else $error("Active compare A changed mid period.");

  chk_pwm_ovf: assert property (
    (fast_pwm && tick && !wr_count && at_top) |=> overflow_flag)
    else $error("PWM overflow flag not set at top.");

  chk_pin_dir: assert property (
    !port_dir[0] |=> wave_out_a_oe_n)
    else $error("Pin A driven while direction is input.");

  chk_port_ctl: assert property (
    (output_action_b == ACT_NONE) |=> wave_out_b == $past(port_data[1]))
    else $error("Pin B not under port control at action zero.");

  chk_read_slot: assert property (
    !rd_en |=> rdata == RST_BYTE)
    else $error("Read data outside the answer cycle.");

  cov_ctc_wrap:  cover property (clear_on_match_mode && top_clear);
  cov_pwm_wrap:  cover property (fast_pwm && top_clear && output_action_a == ACT_CLEAR);
  cov_toggle:    cover property (match_a && output_action_a == ACT_TOGGLE);
  cov_ovf_race:  cover property (wrap_ovf && ovf_ack);

endmodule

// ### tb/tmrwm_load.sv
`timescale 1ns/1ps
// Load on the two waveform pins; a weak pull-down holds an undriven pin low.
module tmrwm_load (
  input  wire logic        clk,
  input  wire logic        wave_out_a,
  input  wire logic        wave_out_a_oe_n,
  input  wire logic        wave_out_b,
  input  wire logic        wave_out_b_oe_n,
  output logic             pin_a,
  output logic             pin_b,
  output logic      [15:0] period_a
);
  logic [15:0] cnt;
  logic        last_a;

  // Level on each pin as the load sees it.
  assign pin_a = wave_out_a_oe_n ? 1'h0 : wave_out_a;
  assign pin_b = wave_out_b_oe_n ? 1'h0 : wave_out_b;

  initial begin
    cnt      = 16'h0000;
    last_a   = 1'h0;
    period_a = 16'h0000;
  end

  // Counts clock cycles between rising edges of pin A.
  always @(posedge clk) begin
    cnt    <= cnt + 16'h0001;
    last_a <= pin_a;
    if (pin_a && !last_a) begin
      period_a <= cnt;
      cnt      <= 16'h0001;
    end
  end
endmodule

// ### tb/timer_waveform_modes_bench.sv
`timescale 1ns/1ps
module timer_waveform_modes_bench
  import tmrwm_pkg::*;
;
  logic        clk, nrst, wr_en, rd_en, pend;
  logic        ovf_ack, cmp_a_ack, cmp_b_ack;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [15:0] period_a;
  logic        overflow_flag, compare_a_flag, compare_b_flag;
  logic        wave_out_a, wave_out_a_oe_n, wave_out_b, wave_out_b_oe_n, pin_a, pin_b;
  logic [7:0]  exp_q[$];
  logic [7:0]  cmps[4];
  logic [2:0]  sels[5] = '{SEL_DIV1, SEL_DIV8, SEL_DIV64, SEL_D256, SEL_D1024};
  int          facs[5] = '{1, 8, 64, 256, 1024};
  int          n_errors, n_checks, seed, h, i, j;

  tmrwm_top dut (.clk, .nrst, .addr, .wdata, .wr_en, .rd_en, .rdata, .ovf_ack, .cmp_a_ack,
    .cmp_b_ack, .overflow_flag, .compare_a_flag, .compare_b_flag, .wave_out_a,
    .wave_out_a_oe_n, .wave_out_b, .wave_out_b_oe_n);

  tmrwm_load load (.clk, .wave_out_a, .wave_out_a_oe_n, .wave_out_b, .wave_out_b_oe_n,
    .pin_a, .pin_b, .period_a);

  // Free-running 200 MHz clock.
  always #2.5 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'h1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_en <= 1'h1;
    addr  <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'h0;
  endtask

  task automatic setup(input logic [2:0] m, input logic [1:0] act, input logic [2:0] s);
    wr(OFS_CTRL_A, {act, ACT_NONE, 2'h0, m[1:0]});
    wr(OFS_CTRL_B, {4'h0, m[2], s});
  endtask

  // Counts the cycles in which pin A is high over a window.
  task automatic meas(input int n);
    h = 0;
    repeat (n) begin
      @(posedge clk);
      if (pin_a === 1'h1) h++;
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Read data stands in the cycle after the strobe; the oldest note is compared.
  always @(posedge clk) begin
    pend <= rd_en;
    if (pend === 1'h1) check(16'(rdata), 16'(exp_q.pop_front()));
  end

  // Stops a hung run.
  initial begin
    #400000;
    n_errors++;
    tally_and_finish;
  end

  initial begin
    seed = 32'h016a_a320;
    {clk, nrst, wr_en, rd_en, pend, ovf_ack, cmp_a_ack, cmp_b_ack} = 8'h00;
    addr = 4'h0;
    wdata = 8'h00;
    n_errors = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    check(16'({wave_out_a, wave_out_b, overflow_flag}), 16'h0000);
    check(16'({wave_out_a_oe_n, wave_out_b_oe_n}), 16'h0003);
    rd(OFS_COUNT, RST_BYTE);
    rd(4'h8, 8'h00);
    wr(OFS_COUNT, 8'h5a);
    rd(OFS_COUNT, 8'h5a);
    $display("test reset and access done");
    // Normal mode wraps and raises the overflow flag, then the flags are cleared.
    wr(OFS_CMP_A, 8'h80);
    wr(OFS_COUNT, 8'hfd);
    wr(OFS_FLAGS, 8'h07);
    setup(MODE_NORMAL, ACT_NONE, SEL_DIV1);
    for (i = 0; i < 12 && overflow_flag !== 1'h1; i++) @(posedge clk);
    check(16'(overflow_flag), 16'h0001);
    check(16'(compare_a_flag), 16'h0000);
    for (i = 0; i < 300 && compare_a_flag !== 1'h1; i++) @(posedge clk);
    check(16'(compare_a_flag), 16'h0001);
    setup(MODE_NORMAL, ACT_NONE, SEL_STOP);
    repeat (4) @(posedge clk);
    ovf_ack   <= 1'h1;
    cmp_a_ack <= 1'h1;
    cmp_b_ack <= 1'h1;
    @(posedge clk);
    {ovf_ack, cmp_a_ack, cmp_b_ack} <= 3'h0;
    @(posedge clk);
    check(16'({overflow_flag, compare_a_flag, compare_b_flag}), 16'h0000);
    // A count write equal to compare A hides that match.
    wr(OFS_CMP_A, 8'h10);
    wr(OFS_COUNT, 8'h10);
    setup(MODE_NORMAL, ACT_NONE, SEL_DIV1);
    repeat (20) @(posedge clk);
    check(16'(compare_a_flag), 16'h0000);
    $display("test normal mode done");
    // Compare A below the count: the counter runs through the wrap first.
    setup(MODE_NORMAL, ACT_NONE, SEL_STOP);
    wr(OFS_CMP_A, 8'h01);
    wr(OFS_COUNT, 8'h32);
    wr(OFS_FLAGS, 8'h07);
    wr(OFS_PORT_DIR, 8'h01);
    setup(MODE_CLR_MATCH, ACT_TOGGLE, SEL_DIV1);
    for (i = 0; i < 300 && overflow_flag !== 1'h1; i++) @(posedge clk);
    check(16'({overflow_flag, compare_a_flag}), 16'h0002);
    wr(OFS_FLAGS, 8'h07);
    meas(64);
    check(16'(h), 16'd32);
    wr(OFS_PORT_DIR, 8'h00);
    repeat (2) @(posedge clk);
    meas(64);
    check(16'(h + pin_b), 16'd0);
    wr(OFS_PORT_DIR, 8'h01);
    for (i = 0; i < 5; i++) begin
      setup(MODE_CLR_MATCH, ACT_TOGGLE, sels[i]);
      repeat (12 * facs[i]) @(posedge clk);
      check(period_a, 16'(4 * facs[i]));
    end
    check(16'({overflow_flag, compare_a_flag}), 16'h0001);
    for (i = 0; i < 3; i++) begin
      wr(OFS_PORT_DATA, 8'(i == 2));
      setup(MODE_CLR_MATCH, i == 0 ? ACT_SET : i == 1 ? ACT_CLEAR : ACT_NONE, SEL_DIV1);
      repeat (8) @(posedge clk);
      meas(32);
      check(16'(h), i == 1 ? 16'd0 : 16'd32);
    end
    wr(OFS_PORT_DATA, 8'h00);
    $display("test clear on match done");
    // Fast PWM duty for random and extreme compare values, both polarities.
    cmps = '{8'($random(seed)), 8'($random(seed)), 8'h00, 8'hff};
    for (i = 0; i < 4; i++) begin
      for (j = 0; j < 2; j++) begin
        setup(MODE_FPWM_MAX, j ? ACT_SET : ACT_CLEAR, SEL_DIV1);
        wr(OFS_CMP_A, cmps[i]);
        wr(OFS_FLAGS, 8'h07);
        repeat (600) @(posedge clk);
        meas(256);
        check(16'(h), j ? 16'h00ff - 16'(cmps[i]) : 16'(cmps[i]) + 16'h0001);
        check(16'(overflow_flag), 16'h0001);
      end
    end
    $display("test fast pwm done");
    // Toggle in fast PWM only with compare A as top.
    setup(MODE_FPWM_CMP, ACT_TOGGLE, SEL_DIV1);
    wr(OFS_CMP_A, 8'h09);
    repeat (600) @(posedge clk);
    meas(200);
    check(16'(h), 16'd100);
    check(period_a, 16'd20);
    setup(MODE_FPWM_MAX, ACT_TOGGLE, SEL_DIV1);
    repeat (8) @(posedge clk);
    meas(200);
    check(16'(h), 16'd0);
    $display("test pwm toggle done");
    tally_and_finish;
  end
endmodule
